/* File: common/wdt_pkg.sv */
package wdt_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] OFF_MODE   = 12'h000;
  localparam logic [11:0] OFF_TCONST = 12'h004;
  localparam logic [11:0] OFF_FEED   = 12'h008;
  localparam logic [11:0] OFF_COUNT  = 12'h00c;
  localparam logic [11:0] OFF_WARN   = 12'h010;
  localparam logic [11:0] OFF_WINDOW = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;
  localparam logic [11:0] OFF_MASK   = 12'h01c;

  // mode register fields
  localparam int MODE_ENABLE_BIT = 0;
  localparam int MODE_RSTEN_BIT  = 1;
  localparam int MODE_RSTFLG_BIT = 2;

  // status and mask register fields
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_WARN_BIT    = 1;
  localparam int ST_FEED_BIT    = 2;
  localparam int ST_WINDOW_BIT  = 3;

  // feed sequence values
  localparam logic [7:0] FEED_FIRST  = 8'haa;
  localparam logic [7:0] FEED_SECOND = 8'h55;

  // values after reset and limits
  localparam logic [23:0] TCONST_RST  = 24'h0000ff;
  localparam logic [23:0] TCONST_MIN  = 24'h0000ff;
  localparam logic [23:0] COUNT_RST   = 24'hffffff;
  localparam logic [23:0] WARN_RST    = 24'h000000;
  localparam logic [23:0] WINDOW_RST  = 24'hffffff;
  localparam logic [3:0]  STATUS_RST  = 4'h0;
  localparam logic [3:0]  MASK_RST    = 4'h0;

  // prescaler divides the watchdog clock by four
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // chip reset request lasts this many pclk cycles plus one
  localparam logic [3:0] RST_PULSE_CYCLES = 4'hf;

endpackage : wdt_pkg

/* File: hw/wdt_tick_gen.sv */
`timescale 1ns/100ps
// watchdog clock synchroniser and fixed divide-by-four prescaler
module wdt_tick_gen (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic watchdog_clock,
  output logic      tick
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [1:0] pre;
    logic       tick;
  } tick_state_t;

  tick_state_t state_ff;
  tick_state_t nxt_state;

  // count rising edges of the synchronised watchdog clock, pulse every fourth
  always_comb begin
    nxt_state       = state_ff;
    nxt_state.tick  = 1'b0;
    nxt_state.sync1 = watchdog_clock;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev  = state_ff.sync2;
    if (state_ff.sync2 && !state_ff.prev) begin
      if (state_ff.pre == wdt_pkg::PRESCALE_LAST) begin
        nxt_state.pre  = 2'h0;
        nxt_state.tick = 1'b1;
      end else begin
        nxt_state.pre = state_ff.pre + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign tick = state_ff.tick;

endmodule : wdt_tick_gen

/* File: hw/windowed_watchdog.sv */
`timescale 1ns/100ps
// Functional notes
// - counter reaching zero without a reload resets the chip, or interrupts when reset reaction is off.
// - with a window set, a feed while count exceeds window is a fault.
// - warning interrupt flag sets when count passes programmed warning value.
// - software may set enable but never clear it; faults clear it.
// - malformed feed sequence resets chip, or interrupts when reset reaction is off.
// - a readable flag records that the watchdog requested a chip reset.
// - time-out counter is 24 bits, stepped through a fixed prescaler.
// - time-out ranges 256 to 2^24 ticks, each tick four watchdog clocks.
// - counter advances only on the dedicated watchdog clock.
module windowed_watchdog (
  // clock, reset and clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // watchdog oscillator pin, asynchronous to pclk
  input  wire logic        watchdog_clock,
  // apb slave port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt line and chip reset request
  output logic             irq,
  output logic             chip_reset_req
);

  // feed sequencer, gray coded
  typedef enum logic [1:0] {
    FEED_IDLE  = 2'b00,
    FEED_ARMED = 2'b01
  } feed_state_t;

  // all state of the block in one register
  typedef struct packed {
    // feed sequencer and mode bits
    feed_state_t feed;
    logic        enable;
    logic        rst_en;
    logic        rst_flag;
    // programmed values and the counter
    logic [23:0] tconst;
    logic [23:0] count;
    logic [23:0] warn;
    logic [23:0] window;
    // sticky event flags and their mask
    logic [3:0]  status;
    logic [3:0]  mask;
    // chip reset pulse and interrupt line
    logic [3:0]  rst_cnt;
    logic        rst_req;
    logic        irq;
    // apb answer
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdt_state_t;

  // registered state and its next value
  wdt_state_t state_ff;
  wdt_state_t nxt_state;
  // one-cycle pulse per four watchdog clock periods
  logic       tick;

  // address match for one register word
  // full twelve-bit compare, so aliases of a word are not decoded
  function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] off);
    is_reg = (addr == off);
  endfunction : is_reg

  // any mapped register word; unaligned and unlisted words answer with an error
  function automatic logic is_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    if (is_reg(addr, wdt_pkg::OFF_MODE)) begin
      hit = 1'b1;
    end else if (is_reg(addr, wdt_pkg::OFF_TCONST)) begin
      hit = 1'b1;
    end else if (is_reg(addr, wdt_pkg::OFF_FEED)) begin
      hit = 1'b1;
    end else if (is_reg(addr, wdt_pkg::OFF_COUNT)) begin
      hit = 1'b1;
    end else if (is_reg(addr, wdt_pkg::OFF_WARN)) begin
      hit = 1'b1;
    end else if (is_reg(addr, wdt_pkg::OFF_WINDOW)) begin
      hit = 1'b1;
    end else if (is_reg(addr, wdt_pkg::OFF_STATUS)) begin
      hit = 1'b1;
    end else if (is_reg(addr, wdt_pkg::OFF_MASK)) begin
      hit = 1'b1;
    end
    is_mapped = hit;
  endfunction : is_mapped

  // one step down of the 24-bit counter; callers never pass zero
  function automatic logic [23:0] dec24(input logic [23:0] value);
    dec24 = value - 24'h000001;
  endfunction : dec24

  // sticky flags: an event in the same cycle beats a write-one-to-clear
  function automatic logic [3:0] sticky4(input logic [3:0] held, input logic [3:0] clr, input logic [3:0] ev);
    sticky4 = (held & ~clr) | ev;
  endfunction : sticky4

  // tick source running off the watchdog oscillator
  // the oscillator pin is asynchronous; all crossing happens in the tick module
  wdt_tick_gen u_tick (
    .pclk           (pclk),
    .presetn        (presetn),
    .ce             (ce),
    .watchdog_clock (watchdog_clock),
    .tick           (tick)
  );

  // apb slave, feed sequencer, counter and event flags
  always_comb begin
    // per-cycle strobes and events, all recomputed every cycle
    logic        acc_first;
    logic        wr_done;
    logic        feed_wr;
    logic        feed_ok;
    logic        fault;
    logic        timeout;
    logic        feed_bad;
    logic        win_bad;
    logic        warn_hit;
    logic        reload;
    logic [3:0]  st_set;
    logic [3:0]  st_clr;
    logic        flag_clr;
    logic [31:0] rdata;
    // defaults: every register holds unless a branch below moves it
    acc_first = 1'b0;
    wr_done   = 1'b0;
    feed_wr   = 1'b0;
    feed_ok   = 1'b0;
    fault     = 1'b0;
    timeout   = 1'b0;
    feed_bad  = 1'b0;
    win_bad   = 1'b0;
    warn_hit  = 1'b0;
    reload    = 1'b0;
    st_set    = 4'h0;
    st_clr    = 4'h0;
    flag_clr  = 1'b0;
    rdata     = 32'h0000_0000;
    nxt_state = state_ff;

    // first access cycle raises pready; write lands on the edge that sees it
    // exactly one wait state on every access, reads and writes alike
    acc_first = psel && penable && !state_ff.pready;
    wr_done   = psel && penable && state_ff.pready && pwrite;
    nxt_state.pready  = acc_first;
    nxt_state.pslverr = acc_first && !is_mapped(paddr);

    // read mux, sampled one cycle ahead of the completing edge
    // unmapped words and the write-only feed word read as zero
    if (is_reg(paddr, wdt_pkg::OFF_MODE)) begin
      rdata[wdt_pkg::MODE_ENABLE_BIT] = state_ff.enable;
      rdata[wdt_pkg::MODE_RSTEN_BIT]  = state_ff.rst_en;
      rdata[wdt_pkg::MODE_RSTFLG_BIT] = state_ff.rst_flag;
    end else if (is_reg(paddr, wdt_pkg::OFF_TCONST)) begin
      rdata[23:0] = state_ff.tconst;
    end else if (is_reg(paddr, wdt_pkg::OFF_COUNT)) begin
      rdata[23:0] = state_ff.count;
    end else if (is_reg(paddr, wdt_pkg::OFF_WARN)) begin
      rdata[23:0] = state_ff.warn;
    end else if (is_reg(paddr, wdt_pkg::OFF_WINDOW)) begin
      rdata[23:0] = state_ff.window;
    end else if (is_reg(paddr, wdt_pkg::OFF_STATUS)) begin
      rdata[3:0] = state_ff.status;
    end else if (is_reg(paddr, wdt_pkg::OFF_MASK)) begin
      rdata[3:0] = state_ff.mask;
    end
    if (acc_first && !pwrite) begin
      nxt_state.prdata = rdata;
    end

    // register writes other than the feed register
    // enable and reset reaction can only be set here; faults clear them
    if (wr_done) begin
      if (is_reg(paddr, wdt_pkg::OFF_MODE)) begin
        if (pwdata[wdt_pkg::MODE_ENABLE_BIT] && !state_ff.enable) begin
          nxt_state.enable = 1'b1;
          nxt_state.count  = state_ff.tconst;
        end
        if (pwdata[wdt_pkg::MODE_RSTEN_BIT]) begin
          nxt_state.rst_en = 1'b1;
        end
        flag_clr = pwdata[wdt_pkg::MODE_RSTFLG_BIT];
      end else if (is_reg(paddr, wdt_pkg::OFF_TCONST)) begin
        // shortest time-out is 256 ticks; smaller values clamp so software
        // cannot program a period shorter than the counter allows
        if (pwdata[23:0] < wdt_pkg::TCONST_MIN) begin
          nxt_state.tconst = wdt_pkg::TCONST_MIN;
        end else begin
          nxt_state.tconst = pwdata[23:0];
        end
      end else if (is_reg(paddr, wdt_pkg::OFF_WARN)) begin
        nxt_state.warn = pwdata[23:0];
      end else if (is_reg(paddr, wdt_pkg::OFF_WINDOW)) begin
        nxt_state.window = pwdata[23:0];
      end else if (is_reg(paddr, wdt_pkg::OFF_STATUS)) begin
        st_clr = pwdata[3:0];
      end else if (is_reg(paddr, wdt_pkg::OFF_MASK)) begin
        nxt_state.mask = pwdata[3:0];
      end else if (is_reg(paddr, wdt_pkg::OFF_COUNT)) begin
        // the count is read only; a write leaves it alone
      end
    end

    // feed sequence: first value, then second value on the very next write
    // any write at all between the two values breaks the sequence
    feed_wr = wr_done && is_reg(paddr, wdt_pkg::OFF_FEED);
    case (state_ff.feed)
      FEED_IDLE: begin
        if (feed_wr) begin
          if (pwdata[7:0] == wdt_pkg::FEED_FIRST) begin
            nxt_state.feed = FEED_ARMED;
          end else begin
            feed_bad = state_ff.enable;
          end
        end
      end
      FEED_ARMED: begin
        if (wr_done) begin
          nxt_state.feed = FEED_IDLE;
          if (feed_wr && pwdata[7:0] == wdt_pkg::FEED_SECOND) begin
            feed_ok = 1'b1;
          end else begin
            feed_bad = state_ff.enable;
          end
        end
      end
      default: begin
        nxt_state.feed = FEED_IDLE;
      end
    endcase

    // feeding above the window is early; a full window disables the check
    // the window is compared with the registered count, before any tick
    if (feed_ok && state_ff.enable) begin
      if (state_ff.count > state_ff.window) begin
        win_bad = 1'b1;
      end else begin
        reload          = 1'b1;
        nxt_state.count = state_ff.tconst;
      end
    end

    // countdown on prescaled watchdog clock ticks
    // a reload in the same cycle wins: a tick must not undo a good feed,
    // nor may a feed that lands with the count at zero still time out
    if (tick && state_ff.enable && !reload) begin
      if (state_ff.count == 24'h000000) begin
        timeout = 1'b1;
      end else begin
        nxt_state.count = dec24(state_ff.count);
        warn_hit        = dec24(state_ff.count) == state_ff.warn;
      end
    end

    // fault reaction: chip reset, or interrupt when reset reaction is off
    // every fault drops the enable and parks the count at the time constant,
    // so a later enable starts a full period; reset reaction is one-shot
    fault = timeout || feed_bad || win_bad;
    st_set[wdt_pkg::ST_WARN_BIT] = warn_hit;
    if (fault) begin
      nxt_state.enable = 1'b0;
      nxt_state.feed   = FEED_IDLE;
      nxt_state.count  = state_ff.tconst;
      if (state_ff.rst_en) begin
        nxt_state.rst_req = 1'b1;
        nxt_state.rst_cnt = wdt_pkg::RST_PULSE_CYCLES;
        nxt_state.rst_en  = 1'b0;
      end else begin
        st_set[wdt_pkg::ST_TIMEOUT_BIT] = timeout;
        st_set[wdt_pkg::ST_FEED_BIT]    = feed_bad;
        st_set[wdt_pkg::ST_WINDOW_BIT]  = win_bad;
      end
    end

    // reset flag and status bits: a new event wins over a clear
    // the flag lives in this block, so chip_reset_req must not loop back to presetn
    if (fault && state_ff.rst_en) begin
      nxt_state.rst_flag = 1'b1;
    end else if (flag_clr) begin
      nxt_state.rst_flag = 1'b0;
    end
    nxt_state.status = sticky4(state_ff.status, st_clr, st_set);

    // hold the chip reset request for a fixed number of cycles
    // a new fault with reset reaction set while the pulse runs restarts the count from the top
    if (state_ff.rst_req && !(fault && state_ff.rst_en)) begin
      if (state_ff.rst_cnt == 4'h0) begin
        nxt_state.rst_req = 1'b0;
      end else begin
        nxt_state.rst_cnt = state_ff.rst_cnt - 4'h1;
      end
    end

    // level interrupt from unmasked sticky bits
    // a mask change shows on the line one cycle after it is written
    nxt_state.irq = |(nxt_state.status & state_ff.mask);
  end

  // state register with clock enable
  // ce low freezes everything, including the bus answer and the prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // values after reset
      state_ff.feed     <= FEED_IDLE;
      state_ff.enable   <= 1'b0;
      state_ff.rst_en   <= 1'b0;
      state_ff.rst_flag <= 1'b0;
      state_ff.tconst   <= wdt_pkg::TCONST_RST;
      state_ff.count    <= wdt_pkg::COUNT_RST;
      state_ff.warn     <= wdt_pkg::WARN_RST;
      state_ff.window   <= wdt_pkg::WINDOW_RST;
      state_ff.status   <= wdt_pkg::STATUS_RST;
      state_ff.mask     <= wdt_pkg::MASK_RST;
      state_ff.rst_cnt  <= 4'h0;
      state_ff.rst_req  <= 1'b0;
      state_ff.irq      <= 1'b0;
      state_ff.pready   <= 1'b0;
      state_ff.pslverr  <= 1'b0;
      state_ff.prdata   <= 32'h0000_0000;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  // nothing combinational reaches a pin
  assign prdata         = state_ff.prdata;
  assign pready         = state_ff.pready;
  assign pslverr        = state_ff.pslverr;
  assign irq            = state_ff.irq;
  assign chip_reset_req = state_ff.rst_req;

endmodule : windowed_watchdog

/* File: test/wdt_checker.sv */
`timescale 1ns/100ps
// watches the apb answer and the chip reset request of the watchdog
module wdt_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        watchdog_clock,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        chip_reset_req
);
  logic [4:0] hi_cnt_ff;

  // length of the current reset request, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt_ff <= 5'h00;
    else if (!chip_reset_req) hi_cnt_ff <= 5'h00;
    else if (hi_cnt_ff != 5'h1f) hi_cnt_ff <= hi_cnt_ff + 5'h01;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answer timing and error reporting
  pready_once_a: assert property (pready && ce |=> !pready) else $error("pready longer than one cycle");
  answer_time_a: assert property (psel && penable && !pready && ce |=> pready) else $error("no answer after one wait");
  pready_phase_a: assert property (pready |-> psel && penable) else $error("pready outside access phase");
  slverr_map_a: assert property (pready |-> pslverr == (paddr > wdt_pkg::OFF_MASK || paddr[1:0] != 2'b00))
    else $error("pslverr wrong for address");
  slverr_qual_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  // register contents seen on reads
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:24] == 8'h00) else $error("upper bits set");
  tconst_min_a: assert property (pready && !pwrite && paddr == wdt_pkg::OFF_TCONST
    |-> prdata[23:0] >= wdt_pkg::TCONST_MIN) else $error("time constant below minimum");
  // chip reset request is one pulse of sixteen cycles
  pulse_len_a: assert property ($fell(chip_reset_req) |-> hi_cnt_ff == 5'h10) else $error("reset pulse length");
  pulse_max_a: assert property (hi_cnt_ff <= 5'h10) else $error("reset pulse too long");

  rst_c: cover property ($rose(chip_reset_req));
  irq_c: cover property ($rose(irq));
  err_c: cover property (pslverr);
endmodule : wdt_checker

bind windowed_watchdog wdt_checker wdt_checker_i (.pclk(pclk), .presetn(presetn), .ce(ce),
  .watchdog_clock(watchdog_clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .chip_reset_req(chip_reset_req));

/* File: test/windowed_watchdog_test.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module windowed_watchdog_test;
  logic        pclk, presetn, ce, watchdog_clock, wd_run;
  logic        psel, penable, pwrite, pready, pslverr, irq, chip_reset_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  int          n_fail, n_tests, cyc, n;

  windowed_watchdog windowed_watchdog_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .watchdog_clock(watchdog_clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .chip_reset_req(chip_reset_req));

  // system clock and a slower free watchdog clock that can be stopped
  initial begin
    pclk = 0;
    forever #4 pclk = !pclk;
  end
  initial begin
    watchdog_clock = 0;
    forever begin
      #32;
      if (wd_run) watchdog_clock = !watchdog_clock;
    end
  end

  task finish_test;
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end

  // one apb transfer: setup, access, wait for pready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task chk(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    apb(0, a, 32'h0);
    `CHK(q & m, x)
  endtask : chk

  task idle(input int k);
    repeat (k) @(posedge pclk);
  endtask : idle

  task feed(input logic [31:0] second);
    apb(1, wdt_pkg::OFF_FEED, 32'haa);
    apb(1, wdt_pkg::OFF_FEED, second);
  endtask : feed

  initial begin
    {psel, penable, pwrite, paddr, pwdata, n_fail, n_tests, cyc} = '0;
    ce = 1;
    wd_run = 1;
    presetn = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    // values after reset and refused accesses
    chk(wdt_pkg::OFF_MODE, 32'h0, 32'hffffffff);
    chk(wdt_pkg::OFF_COUNT, 32'hffffff, 32'hffffffff);
    chk(wdt_pkg::OFF_WINDOW, 32'hffffff, 32'hffffffff);
    apb(0, 12'h020, 32'h0);
    `CHK(e, 1'b1)
    apb(1, wdt_pkg::OFF_TCONST, 32'h10);
    chk(wdt_pkg::OFF_TCONST, 32'hff, 32'hffffffff);
    apb(1, wdt_pkg::OFF_TCONST, 32'hffffffff);
    chk(wdt_pkg::OFF_TCONST, 32'hffffff, 32'hffffffff);
    apb(1, wdt_pkg::OFF_TCONST, 32'hff);
    // enable sticks, a good feed reloads
    apb(1, wdt_pkg::OFF_MASK, 32'hf);
    apb(1, wdt_pkg::OFF_MODE, 32'h1);
    apb(1, wdt_pkg::OFF_MODE, 32'h0);
    chk(wdt_pkg::OFF_MODE, 32'h1, 32'h7);
    idle(300);
    feed(32'h55);
    chk(wdt_pkg::OFF_COUNT, 32'hfe, 32'hfffffe);
    // bad second feed value, then another write between the two feed values
    feed(32'h12);
    idle(2);
    `CHK(irq, 1'b1)
    chk(wdt_pkg::OFF_STATUS, 32'h4, 32'hf);
    chk(wdt_pkg::OFF_MODE, 32'h0, 32'h1);
    apb(1, wdt_pkg::OFF_STATUS, 32'h4);
    idle(2);
    `CHK(irq, 1'b0)
    apb(1, wdt_pkg::OFF_MODE, 32'h1);
    apb(1, wdt_pkg::OFF_FEED, 32'haa);
    apb(1, wdt_pkg::OFF_WARN, 32'h0);
    chk(wdt_pkg::OFF_STATUS, 32'h4, 32'hf);
    apb(1, wdt_pkg::OFF_STATUS, 32'h4);
    // feed while count is above the window
    apb(1, wdt_pkg::OFF_WINDOW, 32'h10);
    apb(1, wdt_pkg::OFF_MODE, 32'h1);
    feed(32'h55);
    chk(wdt_pkg::OFF_STATUS, 32'h8, 32'hf);
    apb(1, wdt_pkg::OFF_STATUS, 32'h8);
    apb(1, wdt_pkg::OFF_WINDOW, 32'hffffff);
    // warning point, then masked
    apb(1, wdt_pkg::OFF_WARN, 32'hfc);
    apb(1, wdt_pkg::OFF_MODE, 32'h1);
    idle(200);
    chk(wdt_pkg::OFF_STATUS, 32'h2, 32'hf);
    `CHK(irq, 1'b1)
    apb(1, wdt_pkg::OFF_MASK, 32'h0);
    idle(2);
    `CHK(irq, 1'b0)
    // time-out with reset reaction: 256 ticks of 32 pclk after the reload
    apb(1, wdt_pkg::OFF_MODE, 32'h3);
    feed(32'h55);
    n = 0;
    while (chip_reset_req !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n >= 8150 && n <= 8210, 1'b1)
    idle(20);
    chk(wdt_pkg::OFF_MODE, 32'h4, 32'h7);
    apb(1, wdt_pkg::OFF_MODE, 32'h4);
    chk(wdt_pkg::OFF_MODE, 32'h0, 32'h7);
    // without the watchdog clock the count stands still
    wd_run <= 0;
    apb(1, wdt_pkg::OFF_MODE, 32'h1);
    idle(200);
    chk(wdt_pkg::OFF_COUNT, 32'hff, 32'hffffff);
    // clock enable low freezes the count although the watchdog clock runs again
    ce <= 0;
    wd_run <= 1;
    idle(200);
    ce <= 1;
    chk(wdt_pkg::OFF_COUNT, 32'hfe, 32'hfffffe);
    finish_test();
  end
endmodule : windowed_watchdog_test
